// ### hdl/sled_pkg.sv
//----------------------------------------------------------------
// Overview of operation
//----------------------------------------------------------------
// Overview of operation
// - Sample all conditions every tenth second
// - Operational LED on when running normally
// - Operational LED off in self-test or failure
// - Operational LED blinks during software download
// - Operational LED fast-blinks when panel-selected
// - Failure LED on for fault or reset
// - Failure LED off without failure conditions
// - Failure LED blinks while self-test runs
// - Test LED on for any active test
// - Test LED off with no test
// - Signal LED on unless loss of signal
// - Out-of-frame LED on if event in period
// - Alarm LED on for any receive alarm
// - Error-rate LED follows error-rate threshold
// - Error-rate LED only meaningful under ESF
package sled_pkg;

  //----------------------------------------------------------------
  // Timing
  //----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned SAMPLE_MS      = 100;  // Sampling period
  localparam int unsigned BLINK_HALF_MS  = 500;  // Normal blink half
  localparam int unsigned FAST_HALF_MS   = 100;  // Fast blink half
  localparam int unsigned SAMPLE_CYC_DEF = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int unsigned BLINK_CYC_DEF  = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int unsigned FAST_CYC_DEF   = CLK_HZ / 1000 * FAST_HALF_MS;

  //----------------------------------------------------------------
  // Register map (byte offsets)
  //----------------------------------------------------------------
  localparam logic [3:0] OFF_CTRL     = 4'h0;
  localparam logic [3:0] OFF_LEDS     = 4'h4;
  localparam logic [3:0] OFF_IRQ_STAT = 4'h8;
  localparam logic [3:0] OFF_IRQ_MASK = 4'hC;
  localparam logic       CTRL_RST     = 1'h1;  // ESF framing assumed
  localparam logic [3:0] MASK_RST     = 4'h0;
  localparam int         IRQ_W        = 4;
  localparam int         LED_W        = 7;
  // Interrupt bit positions
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_OOF   = 1;
  localparam int IRQ_FAIL  = 2;
  localparam int IRQ_TEST  = 3;

  //----------------------------------------------------------------
  // Types
  //----------------------------------------------------------------
  typedef struct packed {
    logic self_test;   // Power-up or commanded self-test
    logic sys_fault;   // Device error or fault
    logic download;    // Software download active
    logic panel_sel;   // Selected by shared_diagnostic_panel
    logic test_local;  // Locally started test
    logic test_net;    // Network started test
    logic test_ext;    // Externally started test
    logic rx_los;      // Loss of signal
    logic rx_oof;      // Out-of-frame event pulse
    logic rx_lof;      // Loss of frame
    logic excessive_error_rate;
    logic rx_yellow;   // Yellow alarm
    logic rx_ais;      // Alarm indication signal
  } sled_cond_type;

  typedef struct packed {
    logic ok;                     // Operational state
    logic fail;                   // Failure
    logic test;                   // Test active
    logic rx_signal_present_led;  // Network signal
    logic oof;                    // Out of frame
    logic rx_alarm_led;           // Network alarm
    logic err_rate_led;           // Error rate
  } sled_led_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } sled_bus_type;

endpackage

// ### hdl/sled_top.sv
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module sled_top
  import sled_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC_DEF,
  parameter int unsigned BLINK_CYCLES  = BLINK_CYC_DEF,
  parameter int unsigned FAST_CYCLES   = FAST_CYC_DEF
) (
  input  wire logic          ref_clk_in,
  input  wire logic          rst_n_in,
  input  wire sled_cond_type cond_in,
  input  wire logic [3:0]    avs_address_in,
  input  wire logic          avs_read_in,
  input  wire logic          avs_write_in,
  input  wire logic [31:0]   avs_writedata_in,
  input  wire logic [3:0]    avs_byteenable_in,
  output var  logic [31:0]   avs_readdata_out,
  output var  logic          avs_waitrequest_out,
  output var  logic          irq_out,
  output var  sled_led_type  led_out
);

  //----------------------------------------------------------------
  // Reset synchroniser
  //----------------------------------------------------------------
  logic       rst_meta_reg;  // First stage
  logic       rst_n;         // Released copy

  // Assert at once, release after two edges
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  //----------------------------------------------------------------
  // Sampling tick
  //----------------------------------------------------------------
  logic [31:0]   smp_cnt_reg;   // Sample prescaler
  logic          tick;          // Last cycle of period
  sled_cond_type smp_reg;       // Sampled conditions
  sled_cond_type smp_next;      // Value taken at tick
  logic          oof_acc_reg;   // Out-of-frame seen in period
  logic          oof_smp_reg;   // Out-of-frame of last period
  logic          rst_hold_reg;  // Reset just occurred

  assign tick = (smp_cnt_reg == 32'(SAMPLE_CYCLES - 1));

  // Period counter
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      smp_cnt_reg <= 32'h0;
    end else if (tick) begin
      smp_cnt_reg <= 32'h0;
    end else begin
      smp_cnt_reg <= smp_cnt_reg + 32'h1;
    end
  end

  assign smp_next = cond_in;

  // Level conditions latched once per period
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      smp_reg <= '0;
    end else if (tick) begin
      smp_reg <= smp_next;
    end
  end

  // Out-of-frame events gathered over the period; a late event wins
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      oof_acc_reg <= 1'b0;
      oof_smp_reg <= 1'b0;
    end else if (tick) begin
      oof_smp_reg <= oof_acc_reg | cond_in.rx_oof;
      oof_acc_reg <= 1'b0;
    end else if (cond_in.rx_oof) begin
      oof_acc_reg <= 1'b1;
    end
  end

  // Failure LED held on for the first period after reset
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rst_hold_reg <= 1'b1;
    end else if (tick) begin
      rst_hold_reg <= 1'b0;
    end
  end

  //----------------------------------------------------------------
  // Blink prescalers
  //----------------------------------------------------------------
  logic [1:0] phase;  // Index 0 normal, 1 fast

  generate
    for (genvar g = 0; g < 2; g++) begin : g_blink
      localparam int unsigned LIM = (g == 0) ? BLINK_CYCLES : FAST_CYCLES;
      logic [31:0] cnt_reg;    // Half period counter
      logic        phase_reg;  // Blink phase
      // Toggle the phase every half period
      always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          cnt_reg   <= 32'h0;
          phase_reg <= 1'b0;
        end else if (cnt_reg == 32'(LIM - 1)) begin
          cnt_reg   <= 32'h0;
          phase_reg <= ~phase_reg;
        end else begin
          cnt_reg <= cnt_reg + 32'h1;
        end
      end
      assign phase[g] = phase_reg;
    end
  endgenerate

  //----------------------------------------------------------------
  // Control register
  //----------------------------------------------------------------
  logic esf_reg;  // ESF framing in use

  //----------------------------------------------------------------
  // LED drive
  //----------------------------------------------------------------
  sled_led_type led_next;  // Next LED pattern
  logic         any_test;  // Any test of any origin
  logic         alarm;     // Any receive alarm

  assign any_test = smp_reg.test_local | smp_reg.test_net |
                    smp_reg.test_ext;
  assign alarm    = smp_reg.rx_los | smp_reg.rx_lof |
                    smp_reg.excessive_error_rate |
                    smp_reg.rx_yellow | smp_reg.rx_ais;

  // Decode sampled state into LED pattern
  always_comb begin
    led_next = '0;
    // Operational LED: off wins, then fast, then normal blink
    if (smp_reg.self_test || smp_reg.sys_fault) begin
      led_next.ok = 1'b0;
    end else if (smp_reg.panel_sel) begin
      led_next.ok = phase[1];
    end else if (smp_reg.download) begin
      led_next.ok = phase[0];
    end else begin
      led_next.ok = 1'b1;
    end
    // Failure LED: self-test blink wins over steady on
    if (smp_reg.self_test) begin
      led_next.fail = phase[0];
    end else if (smp_reg.sys_fault || rst_hold_reg) begin
      led_next.fail = 1'b1;
    end else begin
      led_next.fail = 1'b0;
    end
    led_next.test                  = any_test;
    led_next.rx_signal_present_led = ~smp_reg.rx_los;
    led_next.oof                   = oof_smp_reg;
    led_next.rx_alarm_led          = alarm;
    // Error-rate indication suppressed outside ESF
    led_next.err_rate_led = smp_reg.excessive_error_rate & esf_reg;
  end

  // LED outputs straight from flops
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      led_out <= '0;
    end else begin
      led_out <= led_next;
    end
  end

  //----------------------------------------------------------------
  // Avalon-MM slave
  //----------------------------------------------------------------
  sled_bus_type     bus_reg;    // Handshake state
  logic             req;        // Request pending
  logic             wr_take;    // Write takes effect
  logic [IRQ_W-1:0] stat_reg;   // Sticky events
  logic [IRQ_W-1:0] mask_reg;   // Interrupt enables
  logic [IRQ_W-1:0] evt;        // Events this cycle
  logic [IRQ_W-1:0] clr;        // Write-one-to-clear

  // Address match for one register
  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    return a == o;
  endfunction

  assign req     = avs_read_in | avs_write_in;
  assign wr_take = (bus_reg == BUS_ACK) && avs_write_in &&
                   avs_byteenable_in[0];

  // Answer one cycle after the request; waitrequest low one cycle
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bus_reg             <= BUS_IDLE;
      avs_waitrequest_out <= 1'b1;
    end else begin
      unique case (bus_reg)
        BUS_IDLE: begin
          if (req) begin
            bus_reg             <= BUS_ACK;
            avs_waitrequest_out <= 1'b0;
          end
        end
        BUS_ACK: begin
          bus_reg             <= BUS_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
        default: begin
          bus_reg             <= BUS_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
      endcase
    end
  end

  // Read data loaded as waitrequest drops; unmapped reads zero
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_out <= 32'h0;
    end else if (bus_reg == BUS_IDLE && avs_read_in) begin
      avs_readdata_out <= 32'h0;
      if (hit(avs_address_in, OFF_CTRL)) begin
        avs_readdata_out[0] <= esf_reg;
      end else if (hit(avs_address_in, OFF_LEDS)) begin
        avs_readdata_out[LED_W-1:0] <= led_out;
      end else if (hit(avs_address_in, OFF_IRQ_STAT)) begin
        avs_readdata_out[IRQ_W-1:0] <= stat_reg;
      end else if (hit(avs_address_in, OFF_IRQ_MASK)) begin
        avs_readdata_out[IRQ_W-1:0] <= mask_reg;
      end
    end
  end

  // Control and mask writes
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      esf_reg  <= CTRL_RST;
      mask_reg <= MASK_RST;
    end else if (wr_take) begin
      if (hit(avs_address_in, OFF_CTRL)) begin
        esf_reg <= avs_writedata_in[0];
      end
      if (hit(avs_address_in, OFF_IRQ_MASK)) begin
        mask_reg <= avs_writedata_in[IRQ_W-1:0];
      end
    end
  end

  //----------------------------------------------------------------
  // Interrupts
  //----------------------------------------------------------------
  // Alarm, failure and test events are new conditions at a sampling tick; out-of-frame is any event in the period
  assign evt[IRQ_ALARM] = tick & ~alarm &
                          (smp_next.rx_los | smp_next.rx_lof |
                           smp_next.excessive_error_rate |
                           smp_next.rx_yellow | smp_next.rx_ais);
  assign evt[IRQ_OOF]   = tick & (oof_acc_reg | cond_in.rx_oof);
  assign evt[IRQ_FAIL]  = tick & smp_next.sys_fault & ~smp_reg.sys_fault;
  assign evt[IRQ_TEST]  = tick & ~any_test &
                          (smp_next.test_local | smp_next.test_net |
                           smp_next.test_ext);
  assign clr = (wr_take && hit(avs_address_in, OFF_IRQ_STAT)) ?
               avs_writedata_in[IRQ_W-1:0] : '0;

  generate
    for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
      // Sticky bit; a set in the clear cycle wins
      always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          stat_reg[i] <= 1'b0;
        end else begin
          stat_reg[i] <= (stat_reg[i] & ~clr[i]) | evt[i];
        end
      end
    end
  endgenerate

  // Level interrupt from unmasked sticky bits
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(stat_reg & mask_reg);
    end
  end

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n);

  tick_spacing_a: assert property (tick |=> !tick)
    else $error("Sampling ticks too close");
  smp_hold_a: assert property (!tick |=> $stable(smp_reg))
    else $error("Sample changed between ticks");
  ok_on_a: assert property (!smp_reg.self_test && !smp_reg.sys_fault &&
      !smp_reg.panel_sel && !smp_reg.download |=> led_out.ok)
    else $error("Operational LED not on");
  ok_off_a: assert property ((smp_reg.self_test || smp_reg.sys_fault) &&
      $stable(smp_reg) |=> !led_out.ok)
    else $error("Operational LED not off");
  ok_blink_a: assert property (smp_reg.download && !smp_reg.panel_sel &&
      !smp_reg.self_test && !smp_reg.sys_fault |=> led_out.ok == $past(phase[0]))
    else $error("Operational LED not blinking");
  ok_fast_a: assert property (smp_reg.panel_sel && !smp_reg.self_test &&
      !smp_reg.sys_fault |=> led_out.ok == $past(phase[1]))
    else $error("Operational LED not fast blinking");
  fail_on_a: assert property (smp_reg.sys_fault && !smp_reg.self_test
      |=> led_out.fail)
    else $error("Failure LED not on");
  fail_off_a: assert property (!smp_reg.sys_fault && !smp_reg.self_test &&
      !rst_hold_reg |=> !led_out.fail)
    else $error("Failure LED not off");
  fail_blink_a: assert property (smp_reg.self_test
      |=> led_out.fail == $past(phase[0]))
    else $error("Failure LED not blinking");
  test_led_a: assert property (##1 led_out.test == $past(any_test))
    else $error("Test LED wrong");
  signal_led_a: assert property (tick ##1 !tick
      |=> led_out.rx_signal_present_led == !$past(cond_in.rx_los, 2))
    else $error("Signal LED wrong");
  oof_led_a: assert property (tick && cond_in.rx_oof |-> ##2 led_out.oof)
    else $error("Out-of-frame LED missed event");
  alarm_led_a: assert property (##1 led_out.rx_alarm_led == $past(alarm))
    else $error("Alarm LED wrong");
  err_led_a: assert property (!esf_reg |=> !led_out.err_rate_led)
    else $error("Error-rate LED lit outside ESF");
  blink_rate_a: assert property (g_blink[1].cnt_reg == 32'h0 &&
      $changed(phase[1]) |=> $stable(phase[1]))
    else $error("Fast blink toggled twice");

  // Bus handshake: one wait state, then a single-cycle answer
  bus_answer_a: assert property (bus_reg == BUS_IDLE && req |=> !avs_waitrequest_out)
    else $error("Bus request not answered");
  wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("Waitrequest low too long");
  unmapped_rd_a: assert property (bus_reg == BUS_IDLE && avs_read_in &&
      avs_address_in[1:0] != 2'h0 |=> avs_readdata_out == 32'h0)
    else $error("Unmapped read not zero");
  wr_ignored_a: assert property (bus_reg == BUS_ACK && avs_write_in &&
      !avs_byteenable_in[0] |=> $stable(esf_reg) && $stable(mask_reg))
    else $error("Write without low byte lane took effect");
  // Sticky status: events set, write-one clears, a set in that cycle wins
  stat_set_a: assert property (|evt |=> (stat_reg & $past(evt)) == $past(evt))
    else $error("Status event lost");
  stat_clr_a: assert property (|clr |=> (stat_reg & $past(clr) & ~$past(evt)) == '0)
    else $error("Status bit not cleared");
  irq_level_a: assert property (##1 irq_out == $past(|(stat_reg & mask_reg)))
    else $error("Interrupt level wrong");
  // Sampling and reset indication
  smp_take_a: assert property (tick |=> smp_reg == $past(cond_in))
    else $error("Conditions not taken at tick");
  fail_reset_a: assert property (rst_hold_reg && !smp_reg.self_test |=> led_out.fail)
    else $error("Failure LED not on after reset");

  ok_blink_c: cover property (smp_reg.download && $rose(led_out.ok));
  fast_blink_c: cover property (smp_reg.panel_sel && $fell(led_out.ok));
  oof_c: cover property ($rose(led_out.oof));
  irq_c: cover property ($rose(irq_out));
  fail_blink_c: cover property (smp_reg.self_test && $rose(led_out.fail));

endmodule // sled_top
`default_nettype wire

// ### test/sled_src_model.sv
`timescale 1ns/10ps
`default_nettype none
//----------------------------------------------------------------
// Status sources and front panel observer
//----------------------------------------------------------------
module sled_src_model
  import sled_pkg::*;
(
  input  wire logic          ref_clk_in,    // System clock
  input  wire sled_cond_type req_in,        // Levels asked for by the bench
  input  wire logic          cnt_clr_in,    // Clears the toggle counters
  input  wire sled_led_type  led_in,        // LED drive from the block
  output var  sled_cond_type cond_out,      // Conditions seen by the block
  output var  logic [7:0]    ok_tgl_out,    // Changes of the operational LED
  output var  logic [7:0]    fail_tgl_out   // Changes of the failure LED
);
  sled_led_type led_reg = '0;  // LED state seen one cycle earlier

  initial cond_out = '0;
  // Sources change only just after a rising edge
  always @(posedge ref_clk_in) begin
    cond_out <= req_in;
  end

  // Panel observer counts each change of the blinking LEDs
  always @(posedge ref_clk_in) begin
    led_reg <= led_in;
    if (cnt_clr_in) begin
      ok_tgl_out   <= 8'h00;
      fail_tgl_out <= 8'h00;
    end else begin
      ok_tgl_out   <= ok_tgl_out + 8'((led_reg.ok !== led_in.ok) ? 1 : 0);
      fail_tgl_out <= fail_tgl_out + 8'((led_reg.fail !== led_in.fail) ? 1 : 0);
    end
  end
endmodule // sled_src_model
`default_nettype wire

// ### test/sled_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module sled_top_tb_top;
  import sled_pkg::*;
  //----------------------------------------------------------------
  // Signals
  //----------------------------------------------------------------
  logic ref_clk_in = 1'b0, rst_n_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [3:0] avs_address_in = 4'h0, avs_byteenable_in = 4'h0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
  logic avs_waitrequest_out, irq_out, cnt_clr = 1'b1;
  sled_led_type led_out;
  sled_cond_type cond, req = '0;
  logic [7:0] ok_tgl, fail_tgl;
  int errors = 0, num_checks = 0;
  logic [32:0] notes[$];  // Expected read word, top bit asks for an LED compare
  localparam int SMP = 20;

  sled_top #(.SAMPLE_CYCLES(SMP), .BLINK_CYCLES(8), .FAST_CYCLES(3)) i_sled_top (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cond_in(cond),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out), .led_out(led_out));
  sled_src_model i_sled_src_model (
    .ref_clk_in(ref_clk_in), .req_in(req), .cnt_clr_in(cnt_clr), .led_in(led_out),
    .cond_out(cond), .ok_tgl_out(ok_tgl), .fail_tgl_out(fail_tgl));

  initial begin
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  //----------------------------------------------------------------
  // Checking and closing
  //----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic complete_run;
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Monitor takes the oldest note whenever a read answer stands
  always @(negedge ref_clk_in) begin
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0) begin
      if (notes.size() == 0) begin
        chk("note_queue", 32'h1, 32'h0);
      end else begin
        chk("readdata", notes[0][31:0], avs_readdata_out);
        if (notes[0][32]) begin
          chk("led_out", notes[0][31:0], {25'h0, led_out});
        end
        void'(notes.pop_front());
      end
    end
  end

  //----------------------------------------------------------------
  // Bus and stimulus tasks
  //----------------------------------------------------------------
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    logic wt;
    int n;
    wt = 1'b1;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_write_in <= w;
    avs_read_in <= ~w;
    while (wt === 1'b1 && n < 50) begin
      @(negedge ref_clk_in);
      wt = (avs_waitrequest_out !== 1'b0);
      @(posedge ref_clk_in);
      n++;
    end
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (wt) begin
      errors++;
      complete_run();
    end
    @(posedge ref_clk_in);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic led);
    notes.push_back({led, e});
    bus(1'b0, a, 32'h0, 4'hF);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  // Applies conditions and waits past two sampling ticks
  task automatic set_cond(input sled_cond_type c);
    req <= c;
    repeat (2 * SMP + 5) @(posedge ref_clk_in);
  endtask

  // Counts LED changes over 48 cycles
  task automatic blink(input sled_cond_type c, output logic [7:0] okt, output logic [7:0] flt);
    set_cond(c);
    cnt_clr <= 1'b1;
    @(posedge ref_clk_in);
    cnt_clr <= 1'b0;
    repeat (48) @(posedge ref_clk_in);
    okt = ok_tgl;
    flt = fail_tgl;
  endtask

  task automatic chk_rng(input string nm, input logic [7:0] v, input int lo, input int hi);
    chk(nm, 32'h1, {31'h0, (v >= lo && v <= hi)});
  endtask

  //----------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------
  initial begin
    sled_cond_type c;
    logic [31:0] r;
    logic esf;
    logic [7:0] okt, flt;
    int n;
    void'($urandom(65));
    esf = 1'b1;
    repeat (16) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    rd(OFF_LEDS, 32'h68, 1'b1);
    set_cond('0);
    rd(OFF_LEDS, 32'h48, 1'b1);
    rd(OFF_CTRL, 32'h1, 1'b0);
    rd(4'h2, 32'h0, 1'b0);
    wr(OFF_LEDS, 32'h0);
    rd(OFF_LEDS, 32'h48, 1'b1);
    // Random test and receive conditions, random framing writes
    for (int i = 0; i < 14; i++) begin
      r = $urandom;
      c = '0;
      c[8:5] = r[3:0];
      c[3:0] = r[7:4];
      bus(1'b1, OFF_CTRL, {31'h0, r[8]}, {3'h0, r[9]});
      if (r[9]) begin
        esf = r[8];
      end
      set_cond(c);
      rd(OFF_LEDS, {25'h0, 1'b1, 1'b0, |c[8:6], ~c.rx_los, 1'b0,
         |{c.rx_los, c.rx_lof, c.excessive_error_rate, c.rx_yellow, c.rx_ais},
         c.excessive_error_rate & esf}, 1'b1);
    end
    c = '0;
    c.excessive_error_rate = 1'b1;
    wr(OFF_CTRL, 32'h0);
    set_cond(c);
    rd(OFF_LEDS, 32'h4A, 1'b1);
    wr(OFF_CTRL, 32'h1);
    set_cond(c);
    rd(OFF_LEDS, 32'h4B, 1'b1);
    c = '0;
    c.sys_fault = 1'b1;
    set_cond(c);
    rd(OFF_LEDS, 32'h28, 1'b1);
    // Blink modes of the system LEDs
    c = '0;
    c.download = 1'b1;
    blink(c, okt, flt);
    chk_rng("ok_blink", okt, 5, 7);
    c.panel_sel = 1'b1;
    blink(c, okt, flt);
    chk_rng("ok_fast", okt, 14, 17);
    c = '0;
    c.self_test = 1'b1;
    blink(c, okt, flt);
    chk("ok_self_test", 32'h0, {31'h0, led_out.ok});
    chk_rng("ok_quiet", okt, 0, 0);
    chk_rng("fail_blink", flt, 5, 7);
    // Out-of-frame pulse lights the LED for one sampling period
    set_cond('0);
    req.rx_oof <= 1'b1;
    @(posedge ref_clk_in);
    req.rx_oof <= 1'b0;
    n = 0;
    while (led_out.oof !== 1'b1 && n < 2 * SMP + 5) begin
      @(negedge ref_clk_in);
      n++;
    end
    n = 0;
    while (led_out.oof === 1'b1 && n < 3 * SMP) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk("oof_len", SMP, n);
    @(posedge ref_clk_in);
    // Interrupt status, mask and clear
    set_cond('0);
    wr(OFF_IRQ_STAT, 32'hF);
    rd(OFF_IRQ_STAT, 32'h0, 1'b0);
    rd(OFF_IRQ_MASK, 32'h0, 1'b0);
    wr(OFF_IRQ_MASK, 32'h1);
    c = '0;
    c.rx_los = 1'b1;
    set_cond(c);
    rd(OFF_IRQ_STAT, 32'h1, 1'b0);
    chk("irq_on", 32'h1, {31'h0, irq_out});
    wr(OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge ref_clk_in);
    chk("irq_masked", 32'h0, {31'h0, irq_out});
    wr(OFF_IRQ_MASK, 32'hF);
    repeat (2) @(posedge ref_clk_in);
    chk("irq_unmasked", 32'h1, {31'h0, irq_out});
    set_cond('0);
    wr(OFF_IRQ_STAT, 32'h1);
    rd(OFF_IRQ_STAT, 32'h0, 1'b0);
    chk("irq_cleared", 32'h0, {31'h0, irq_out});
    c = '0;
    c.sys_fault = 1'b1;
    c.test_ext = 1'b1;
    c.rx_oof = 1'b1;
    req <= c;
    @(posedge ref_clk_in);
    c.rx_oof = 1'b0;
    set_cond(c);
    rd(OFF_IRQ_STAT, 32'hE, 1'b0);
    chk("irq_events", 32'h1, {31'h0, irq_out});
    complete_run();
  end

  // Watchdog ends a hung run
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    errors++;
    complete_run();
  end
endmodule // sled_top_tb_top
`default_nettype wire
